/* File: test/clpc_top_asserts.sv */
`timescale 1ns/1ps
// ==========================================================
// Port checker for the controller top
module clpc_top_chk #(
    parameter TICK_CYCLES = 200000
) (
    input logic        clk,
    input logic        srst,
    input logic [15:0] pos_command,
    input logic [15:0] pos_feedback,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic [15:0] set_value,
    input logic        set_value_strobe
);
    logic [31:0] gap_q;
    logic        seen_q;
    wire         bad_a = paddr[7:6] != 2'h0 || paddr[1:0] != 2'h0 || (pwrite && paddr[5:2] >= 4'hD);

    // The gap is only judged once a first strobe has been seen after reset.
    always_ff @(posedge clk) begin
        if (srst) begin
            gap_q  <= 32'h0;
            seen_q <= 1'b0;
        end else if (set_value_strobe) begin
            gap_q  <= 32'h0;
            seen_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 32'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_acc;
        psel && penable && !pready;
    endsequence
    property p_ans;     s_acc |=> pready; endproperty
    property p_rdy_src; pready |-> psel && penable && $past(psel && penable) && !$past(pready); endproperty
    property p_rdy_pul; pready |=> !pready; endproperty
    property p_refuse;  s_acc ##0 bad_a |=> pslverr; endproperty
    property p_accept;  s_acc ##0 !bad_a |=> !pslverr; endproperty
    property p_err_rdy; pslverr |-> pready; endproperty
    property p_rd_hold; $changed(prdata) |-> pready && !pwrite; endproperty
    property p_sv_stb;  $changed(set_value) |-> set_value_strobe; endproperty
    property p_period;  set_value_strobe && seen_q |-> gap_q == TICK_CYCLES - 1; endproperty
    property p_sat;     set_value_strobe |-> $signed(set_value) <= 16'sh2710 && $signed(set_value) >= -16'sh2710;
    endproperty
    property p_rst;     $past(srst) |-> set_value == 16'h0000 && !set_value_strobe && !pready; endproperty

    a_ans:     assert property (p_ans) else $error("no answer in second access cycle");
    a_rdy_src: assert property (p_rdy_src) else $error("ready without a pending access");
    a_rdy_pul: assert property (p_rdy_pul) else $error("ready longer than one cycle");
    a_refuse:  assert property (p_refuse) else $error("bad access not refused");
    a_accept:  assert property (p_accept) else $error("good access refused");
    a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved outside a read");
    a_sv_stb:  assert property (p_sv_stb) else $error("set value moved without strobe");
    a_period:  assert property (p_period) else $error("control period length wrong");
    a_sat:     assert property (p_sat) else $error("set value beyond full scale");
    a_rst:     assert property (p_rst) else $error("outputs not cleared by reset");
endmodule // clpc_top_chk

bind clpc_top clpc_top_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk(clk), .srst(srst), .pos_command(pos_command),
    .pos_feedback(pos_feedback), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .set_value(set_value), .set_value_strobe(set_value_strobe));

/* File: test/clpc_top_tb.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the controller top
module clpc_top_tb;
    localparam integer TICK = 40;
    reg         clk         = 1'b0;
    reg         srst        = 1'b1;
    reg  [15:0] pos_command = 16'h0000;
    reg  [15:0] fb_target   = 16'h0000;
    reg         psel        = 1'b0;
    reg         penable     = 1'b0;
    reg         pwrite      = 1'b0;
    reg  [7:0]  paddr       = 8'h00;
    reg  [31:0] pwdata      = 32'h0;
    wire [15:0] pos_feedback;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire [15:0] set_value;
    wire        set_value_strobe;
    reg  [31:0] rd;
    reg         er;
    integer     miscompares = 0;
    integer     comparisons = 0;
    integer     acc         = 0;
    integer     last_fb     = 0;
    integer     last_y      = 0;
    integer     k;
    integer     regs [0:12];

    always #2.5 clk = ~clk;

    clpc_top #(.TICK_CYCLES(TICK)) i_clpc_top (.clk(clk), .srst(srst), .pos_command(pos_command),
        .pos_feedback(pos_feedback), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .set_value(set_value),
        .set_value_strobe(set_value_strobe));
    clpc_xducer i_clpc_xducer (.clk(clk), .target(fb_target), .pos_feedback(pos_feedback));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wait_hi(input integer sel);
        integer n;
        n = 0;
        do begin
            @(posedge clk);
            n = n + 1;
        end while ((sel ? set_value_strobe : pready) !== 1'b1 && n < 200);
        if (n >= 200) begin
            miscompares = miscompares + 1;
            complete_run;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        wait_hi(0);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input integer idx, input integer v);
        apb(1'b1, 8'(idx * 4), v);
        regs[idx] = v;
    endtask

    task automatic check_map;
        regs = '{8, 100, 0, 0, 2000, 1000, 1, 10000, 10000, -12000, 12000, -12000, 12000};
        for (k = 0; k < 13; k = k + 1) begin
            apb(1'b0, 8'(k * 4), 32'h0);
            chk(rd, regs[k] & 32'h0000FFFF);
        end
    endtask

    function automatic integer sat(input integer v);
        sat = v > 10000 ? 10000 : (v < -10000 ? -10000 : v);
    endfunction

    // Inputs change just after a strobe, so the next tick latches them whole.
    task automatic per(input integer c, input integer f);
        integer e, u, m;
        pos_command <= c[15:0];
        fb_target   <= f[15:0];
        wait_hi(1);
        m = regs[0];
        e = m[0] ? c * regs[8] / 10000 : c - f;
        if ((e < 0 ? -e : e) < (m[2] ? 1 : 100)) e = 0;
        if (regs[4] == 0 || !m[3]) acc = 0;
        else if ((e < 0 ? -e : e) <= regs[4]) acc = acc + regs[2] * e / 10;
        else acc = acc + regs[2] * e / 10 * regs[5] / 1000;
        acc = acc > 10000000 ? 10000000 : (acc < -10000000 ? -10000000 : acc);
        u = sat(regs[1] * e / 10 + acc / 1000 + regs[3] * (f - last_fb) / 10);
        if (m[1]) u = sat(10000 - u);
        if (!m[3] || f <= regs[9] || f >= regs[10]) u = 0;
        else if (f <= regs[11] || f >= regs[12]) u = last_y > 100 ? last_y - 100 : (last_y < -100 ? last_y + 100 : 0);
        chk({{16{set_value[15]}}, set_value}, u);
        last_y  = u;
        last_fb = f;
    endtask

    initial begin
        void'($urandom(56));
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check_map;
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b0, 8'h06, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, 8'h34, 32'h0000_1234);
        chk({31'h0, er}, 32'h1);
        $display("test register map done");
        per(0, 0);
        for (k = 0; k < 8; k = k + 1) begin
            wr(1, $urandom_range(100));
            per($urandom_range(2000) - 1000, $urandom_range(2000) - 1000);
        end
        wr(1, 100);
        per(50, 0);
        wr(0, 12);
        per(50, 0);
        wr(0, 10);
        per(300, 0);
        wr(0, 8);
        wr(3, -500);
        per(300, 20);
        apb(1'b0, 8'h3C, 32'h0);
        chk(rd, 20 * 10000 / 10);
        wr(6, 2);
        per(300, 20);
        apb(1'b0, 8'h3C, 32'h0);
        chk(rd, (20000 + 0) / 2);
        wr(6, 1);
        wr(3, 0);
        wr(2, 1000);
        per(500, 0);
        per(500, 0);
        wr(4, 0);
        per(500, 0);
        $display("test gains done");
        wr(4, 2000);
        wr(2, 0);
        wr(0, 9);
        wr(8, 5000);
        per(400, 0);
        wr(0, 8);
        wr(8, 10000);
        wr(9, 1000);
        per(3000, 500);
        wr(9, -12000);
        wr(10, 2000);
        per(5000, 2500);
        wr(10, 12000);
        per(600, 300);
        wr(12, 200);
        per(600, 300);
        per(600, 300);
        wr(12, 12000);
        per(-300, 0);
        wr(11, 500);
        per(-300, 0);
        per(-300, 0);
        apb(1'b0, 8'h34, 32'h0);
        chk(rd, last_y);
        wr(11, -12000);
        wr(0, 0);
        per(300, 0);
        $display("test stops and ramps done");
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk({16'h0000, set_value}, 32'h0);
        check_map;
        $display("test second reset done");
        complete_run;
    end
endmodule // clpc_top_tb

/* File: test/clpc_xducer.sv */
`timescale 1ns/1ps
// ==========================================================
// Position transducer model
module clpc_xducer (
    input  wire        clk,
    input  wire [15:0] target,
    output reg  [15:0] pos_feedback
);
    // One clock cycle of lag; the feedback copies the target driven by the bench, not the command, so the loop stays open.
    initial pos_feedback = 16'h0000;
    always @(posedge clk) begin
        pos_feedback <= target;
    end
endmodule // clpc_xducer

/* File: verilog/clpc_avg.v */
`timescale 1ns/1ps
// ==========================================================
// Moving average over the last count samples
module clpc_avg #(
    parameter W     = 32,
    parameter DEPTH = 10
) (
    input  wire                clk,
    input  wire                srst,
    input  wire                in_valid,
    input  wire [3:0]          count,
    input  wire signed [W-1:0] sample,
    output reg  signed [W-1:0] avg_q
);
    reg signed [W-1:0]  hist_q [0:DEPTH-2];
    reg signed [W+3:0]  sum;
    reg signed [W+21:0] prod;
    integer             i;
    integer             j;

    // Division by a small count is done with a reciprocal table.
    function [16:0] recip;
        input [3:0] n;
        begin
            case (n)
                4'h2:    recip = 17'h08000;
                4'h3:    recip = 17'h05555;
                4'h4:    recip = 17'h04000;
                4'h5:    recip = 17'h03333;
                4'h6:    recip = 17'h02AAB;
                4'h7:    recip = 17'h02492;
                4'h8:    recip = 17'h02000;
                4'h9:    recip = 17'h01C72;
                4'hA:    recip = 17'h0199A;
                default: recip = 17'h10000;
            endcase
        end
    endfunction

    always @* begin
        sum = {{4{sample[W-1]}}, sample};
        for (i = 0; i < DEPTH - 1; i = i + 1) begin
            if (i + 1 < count) begin
                sum = sum + {{4{hist_q[i][W-1]}}, hist_q[i]};
            end
        end
        prod = sum * $signed({1'b0, recip(count)});
    end

    always @(posedge clk) begin
        if (srst) begin
            for (j = 0; j < DEPTH - 1; j = j + 1) begin
                hist_q[j] <= {W{1'b0}};
            end
            avg_q <= {W{1'b0}};
        end else if (in_valid) begin
            hist_q[0] <= sample;
            for (j = 1; j < DEPTH - 1; j = j + 1) begin
                hist_q[j] <= hist_q[j-1];
            end
            avg_q <= prod[W+15:16];
        end
    end
endmodule // clpc_avg

/* File: verilog/clpc_defs.vh */
`ifndef CLPC_DEFS_VH
`define CLPC_DEFS_VH
// ==========================================================
// Register indices (byte address is four times the index)
`define CLPC_IX_CTRL    4'h0
`define CLPC_IX_PGAIN   4'h1
`define CLPC_IX_IGAIN   4'h2
`define CLPC_IX_DGAIN   4'h3
`define CLPC_IX_IWIN    4'h4
`define CLPC_IX_IWRED   4'h5
`define CLPC_IX_AVGCNT  4'h6
`define CLPC_IX_SENSLEN 4'h7
`define CLPC_IX_MAXSPD  4'h8
`define CLPC_IX_MINSTP  4'h9
`define CLPC_IX_MAXSTP  4'hA
`define CLPC_IX_MINRMP  4'hB
`define CLPC_IX_MAXRMP  4'hC
`define CLPC_IX_SETVAL  4'hD
`define CLPC_IX_STATUS  4'hE
`define CLPC_IX_VEL     4'hF
`define CLPC_IX_LASTW   4'hC
// ==========================================================
// Control register fields
`define CLPC_CTRL_VEL   0
`define CLPC_CTRL_WAVE  1
`define CLPC_CTRL_THR   2
`define CLPC_CTRL_EN    3
// ==========================================================
// Reset values (positions in 0.01 %, gains in 0.1)
`define CLPC_RST_CTRL   16'h0008
`define CLPC_RST_PGAIN  16'h0064
`define CLPC_RST_IWIN   16'h07D0
`define CLPC_RST_IWRED  16'h03E8
`define CLPC_RST_AVG    16'h0001
`define CLPC_RST_LEN    16'h2710
`define CLPC_RST_POSMIN 16'hD120
`define CLPC_RST_POSMAX 16'h2EE0
// ==========================================================
// Limits and scales
`define CLPC_LIM_GAIN   40'sh00000003E8
`define CLPC_LIM_IWIN   40'sh00000007D0
`define CLPC_LIM_AVG    40'sh000000000A
`define CLPC_LIM_LEN    40'sh0000002710
`define CLPC_LIM_POS    40'sh0000002EE0
`define CLPC_FULL       40'sh0000002710
`define CLPC_GSCALE     40'sh000000000A
`define CLPC_ISCALE     40'sh00000003E8
`define CLPC_THR_COARSE 40'sh0000000064
`define CLPC_THR_FINE   40'sh0000000001
// ==========================================================
// Timing
`define CLPC_PERIOD_NS  1000000
`define CLPC_CLK_MHZ    200
`define CLPC_RAMP_STEP  16'h0064
`endif

/* File: verilog/clpc_tick.v */
`timescale 1ns/1ps
// ==========================================================
// Control period divider
module clpc_tick #(
    parameter CYCLES = 200000
) (
    input  wire clk,
    input  wire srst,
    output reg  tick_q
);
    reg [31:0] cnt_q;

    always @(posedge clk) begin
        if (srst) begin
            cnt_q  <= 32'h0;
            tick_q <= 1'b0;
        end else if (cnt_q == CYCLES - 1) begin
            cnt_q  <= 32'h0;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 32'h1;
            tick_q <= 1'b0;
        end
    end
endmodule // clpc_tick

/* File: verilog/clpc_top.v */
`timescale 1ns/1ps
`include "clpc_defs.vh"

// Overview of operation
// - recompute set value once every millisecond
// - output is sum of P, I, D terms
// - P term is gain times control error (position or velocity)
// - integral grows with error toward zero error
// - full integral rate only in window; zero window disables
// - D term follows feedback rate, signed gain
// - velocity feedback averaged over configured samples
// - mode bit picks position or velocity control
// - at min stop point, zero immediately
// - at max stop point, zero immediately
// - at min ramp point, ramp to zero
// - at max ramp point, ramp to zero
// - velocity derived from position and sensor length
// - command span scaled to maximum speed
// - waveform bit selects direct or reversed output
// - threshold bit sets small-error dead band
// - waveform 0 is y=x, 1 is y=1-x
// - outside window integral rate reduced by factor
// - stop and ramp points limited to +-120 percent
module clpc_top #(
    parameter TICK_CYCLES = (`CLPC_PERIOD_NS / 1000) * `CLPC_CLK_MHZ,
    parameter RAMP_STEP   = `CLPC_RAMP_STEP
) (
    input  wire        clk,
    input  wire        srst,
    input  wire [15:0] pos_command,
    input  wire [15:0] pos_feedback,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg  [15:0] set_value,
    output reg         set_value_strobe
);
    reg  [15:0]        cfg_q [0:12];
    reg  [15:0]        act_q [0:12];
    reg  signed [15:0] cmd_q;
    reg  signed [15:0] fb_q;
    reg  signed [15:0] fbp_q;
    reg  signed [39:0] iacc_q;
    reg                st1_q;
    reg                st2_q;
    reg                fade_q;
    reg  [3:0]         flags_q;
    reg  [31:0]        rd;
    reg                bad;
    wire               tick;
    wire signed [31:0] vel_avg;
    wire [3:0]         ix = paddr[5:2];
    integer            k;
    integer            j;

    // ==========================================================
    // Helpers
    function signed [39:0] sat;
        input signed [39:0] v;
        input signed [39:0] lim;
        begin
            if (v > lim) sat = lim;
            else if (v < -lim) sat = -lim;
            else sat = v;
        end
    endfunction

    function signed [39:0] sx;
        input [15:0] v;
        begin
            sx = {{24{v[15]}}, v};
        end
    endfunction

    function signed [39:0] absv;
        input signed [39:0] v;
        begin
            absv = (v < 0) ? -v : v;
        end
    endfunction

    // Writes are limited to each setting's legal range.
    function [15:0] legal;
        input [3:0]  i;
        input [15:0] d;
        reg   [39:0] u;
        reg   signed [39:0] t;
        begin
            u = {24'h0, d};
            case (i)
                `CLPC_IX_CTRL: t = {36'h0, d[3:0]};
                `CLPC_IX_PGAIN, `CLPC_IX_IGAIN, `CLPC_IX_IWRED:
                    t = sat(u, `CLPC_LIM_GAIN);
                `CLPC_IX_DGAIN: t = sat(sx(d), `CLPC_LIM_GAIN);
                `CLPC_IX_IWIN: t = sat(u, `CLPC_LIM_IWIN);
                `CLPC_IX_AVGCNT:
                    t = (d == 16'h0) ? 40'sh1 : sat(u, `CLPC_LIM_AVG);
                `CLPC_IX_SENSLEN, `CLPC_IX_MAXSPD:
                    t = (d == 16'h0) ? 40'sh1 : sat(u, `CLPC_LIM_LEN);
                default: t = sat(sx(d), `CLPC_LIM_POS);
            endcase
            legal = t[15:0];
        end
    endfunction

    function [15:0] rst_val;
        input [3:0] i;
        begin
            case (i)
                `CLPC_IX_CTRL:    rst_val = `CLPC_RST_CTRL;
                `CLPC_IX_PGAIN:   rst_val = `CLPC_RST_PGAIN;
                `CLPC_IX_IWIN:    rst_val = `CLPC_RST_IWIN;
                `CLPC_IX_IWRED:   rst_val = `CLPC_RST_IWRED;
                `CLPC_IX_AVGCNT:  rst_val = `CLPC_RST_AVG;
                `CLPC_IX_SENSLEN: rst_val = `CLPC_RST_LEN;
                `CLPC_IX_MAXSPD:  rst_val = `CLPC_RST_LEN;
                `CLPC_IX_MINSTP:  rst_val = `CLPC_RST_POSMIN;
                `CLPC_IX_MAXSTP:  rst_val = `CLPC_RST_POSMAX;
                `CLPC_IX_MINRMP:  rst_val = `CLPC_RST_POSMIN;
                `CLPC_IX_MAXRMP:  rst_val = `CLPC_RST_POSMAX;
                default:          rst_val = 16'h0000;
            endcase
        end
    endfunction

    // ==========================================================
    // Period tick and velocity averaging
    clpc_tick #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk    (clk),
        .srst   (srst),
        .tick_q (tick)
    );

    wire signed [39:0] dpos    = sx(fb_q) - sx(fbp_q);
    // Stroke fraction per ms times length in mm gives mm/s.
    wire signed [39:0] vel_raw = dpos * sx(act_q[`CLPC_IX_SENSLEN]) / `CLPC_GSCALE;

    clpc_avg #(
        .W     (32),
        .DEPTH (10)
    ) u_avg (
        .clk      (clk),
        .srst     (srst),
        .in_valid (st1_q),
        .count    (act_q[`CLPC_IX_AVGCNT][3:0]),
        .sample   (vel_raw[31:0]),
        .avg_q    (vel_avg)
    );

    // ==========================================================
    // Control law
    wire [15:0] ctl    = act_q[`CLPC_IX_CTRL];
    reg  signed [39:0] err;
    reg  signed [39:0] e;
    reg  signed [39:0] p_t;
    reg  signed [39:0] inc;
    reg  signed [39:0] iacc_d;
    reg  signed [39:0] d_t;
    reg  signed [39:0] u_t;
    reg  signed [39:0] y_t;
    reg  signed [39:0] sv;
    reg  signed [39:0] thr;
    reg                stop_lo;
    reg                stop_hi;
    reg                fade;
    reg                in_win;

    always @* begin
        if (ctl[`CLPC_CTRL_VEL]) begin
            err = sx(cmd_q) * sx(act_q[`CLPC_IX_MAXSPD]) / `CLPC_FULL
                  - {{8{vel_avg[31]}}, vel_avg};
        end else begin
            err = sx(cmd_q) - sx(fb_q);
        end
        thr = ctl[`CLPC_CTRL_THR] ? `CLPC_THR_FINE : `CLPC_THR_COARSE;
        e   = (absv(err) < thr) ? 40'sh0 : err;
        p_t = sx(act_q[`CLPC_IX_PGAIN]) * e / `CLPC_GSCALE;
        inc = sx(act_q[`CLPC_IX_IGAIN]) * e / `CLPC_GSCALE;
        in_win = absv(e) <= sx(act_q[`CLPC_IX_IWIN]);
        if (act_q[`CLPC_IX_IWIN] == 16'h0 || !ctl[`CLPC_CTRL_EN]) begin
            iacc_d = 40'sh0;
        end else if (in_win) begin
            iacc_d = iacc_q + inc;
        end else begin
            iacc_d = iacc_q + inc * sx(act_q[`CLPC_IX_IWRED]) / `CLPC_ISCALE;
        end
        // Clamping the accumulator stops wind-up during long stalls.
        iacc_d = sat(iacc_d, `CLPC_FULL * `CLPC_ISCALE);
        d_t = sx(act_q[`CLPC_IX_DGAIN]) * dpos / `CLPC_GSCALE;
        u_t = sat(p_t + iacc_d / `CLPC_ISCALE + d_t, `CLPC_FULL);
        y_t = ctl[`CLPC_CTRL_WAVE] ? sat(`CLPC_FULL - u_t, `CLPC_FULL) : u_t;
        stop_lo = sx(fb_q) <= sx(act_q[`CLPC_IX_MINSTP]);
        stop_hi = sx(fb_q) >= sx(act_q[`CLPC_IX_MAXSTP]);
        fade    = sx(fb_q) <= sx(act_q[`CLPC_IX_MINRMP])
                  || sx(fb_q) >= sx(act_q[`CLPC_IX_MAXRMP]);
        if (!ctl[`CLPC_CTRL_EN] || stop_lo || stop_hi) begin
            sv = 40'sh0;
        end else if (fade) begin
            if (absv(sx(set_value)) <= sx(RAMP_STEP)) sv = 40'sh0;
            else if (set_value[15]) sv = sx(set_value) + sx(RAMP_STEP);
            else sv = sx(set_value) - sx(RAMP_STEP);
        end else begin
            sv = y_t;
        end
    end

    // ==========================================================
    // Period pipeline: latch settings and inputs, then compute
    always @(posedge clk) begin
        if (srst) begin
            for (k = 0; k <= 12; k = k + 1) begin
                act_q[k] <= rst_val(k[3:0]);
            end
            cmd_q            <= 16'sh0000;
            fb_q             <= 16'sh0000;
            fbp_q            <= 16'sh0000;
            iacc_q           <= 40'sh0;
            st1_q            <= 1'b0;
            st2_q            <= 1'b0;
            fade_q           <= 1'b0;
            flags_q          <= 4'h0;
            set_value        <= 16'h0000;
            set_value_strobe <= 1'b0;
        end else begin
            st1_q            <= tick;
            st2_q            <= st1_q;
            set_value_strobe <= st2_q;
            if (tick) begin
                for (k = 0; k <= 12; k = k + 1) begin
                    act_q[k] <= cfg_q[k];
                end
                cmd_q <= pos_command;
                fb_q  <= pos_feedback;
                fbp_q <= fb_q;
            end
            if (st2_q) begin
                iacc_q    <= iacc_d;
                set_value <= sv[15:0];
                fade_q    <= fade;
                flags_q   <= {in_win, fade, stop_hi, stop_lo};
            end
        end
    end

    // ==========================================================
    // APB slave, one wait state
    always @* begin
        bad = (paddr[7:6] != 2'b00) || (paddr[1:0] != 2'b00)
              || (pwrite && ix > `CLPC_IX_LASTW);
        rd  = 32'h0000_0000;
        if (!bad) begin
            case (ix)
                `CLPC_IX_SETVAL: rd = {{16{set_value[15]}}, set_value};
                `CLPC_IX_STATUS: rd = {27'h0, fade_q, flags_q};
                `CLPC_IX_VEL:    rd = vel_avg;
                default:         rd = {16'h0000, cfg_q[ix]};
            endcase
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            for (j = 0; j <= 12; j = j + 1) begin
                cfg_q[j] <= rst_val(j[3:0]);
            end
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            if (psel && penable && !pready) begin
                pready  <= 1'b1;
                pslverr <= bad;
                // Read data holds across writes, so software keeps its last read word.
                if (!pwrite) begin
                    prdata <= rd;
                end
            end
            if (psel && penable && pready && pwrite && !bad) begin
                cfg_q[ix] <= legal(ix, pwdata[15:0]);
            end
        end
    end
endmodule // clpc_top
